// ==== design/srsf_rx_status.sv ====
// receive shift logic and status flags of the serial communication interface receiver
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
module srsf_rx_status
  import srsf_pkg::*;
#(
  parameter int BIT_CYCLES = SRSF_BIT_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire srsf_bus_req_t bus_req,
  output logic [23:0] rd_data,
  input wire logic rxd,
  input wire logic sw_reset,
  input wire logic stop_req,
  output logic irq
);
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] BIT_HALF = 8'(BIT_CYCLES / 2 - 1);

  srsf_state_t s;
  srsf_state_t next_s;

  logic rd_status;
  logic rd_rxdata;
  logic frame_done;
  logic frame_fe;
  logic word_moved;
  logic flag_clear;
  logic [2:0] mode;
  logic is_async;
  logic has_extra;
  logic is_parity;
  logic [3:0] frame_bits;
  logic [3:0] idle_target;
  logic [7:0] word;
  logic bad_parity;
  logic [2:0] events;
  logic [2:0] w1c;

  assign rd_data = s.rd_data;
  assign irq = |(s.int_stat & s.int_mask);

  always_comb
  begin
    next_s = s;
    next_s.rd_data = 24'h000000;
    next_s.rxd_meta = rxd;
    next_s.rxd_sync = s.rxd_meta;
    mode = s.ctrl[SRSF_CTRL_MODE_LSB +: 3];
    is_async = (mode != SRSF_MODE_SYNC8);
    is_parity = (mode == SRSF_MODE_PAR_EVEN) || (mode == SRSF_MODE_PAR_ODD);
    has_extra = is_parity || (mode == SRSF_MODE_MULTIDROP);
    frame_bits = has_extra ? SRSF_DATA_BITS + 4'h1 : SRSF_DATA_BITS;
    idle_target = has_extra ? SRSF_IDLE_ONES_11 : SRSF_IDLE_ONES_10;
    rd_status = bus_req.rd && (bus_req.addr == SRSF_OFF_STATUS);
    rd_rxdata = bus_req.rd && (bus_req.addr == SRSF_OFF_RXDATA);
    flag_clear = sw_reset || stop_req
      || (bus_req.wr && (bus_req.addr == SRSF_OFF_CTRL) && bus_req.wdata[SRSF_CTRL_INDIV_RST]);
    frame_done = 1'b0;
    frame_fe = 1'b0;
    word_moved = 1'b0;
    // nine bit shifter: an eight bit frame leaves the data one place higher
    word = has_extra ? s.shift[7:0] : s.shift[8:1];
    bad_parity = 1'b0;
    if (mode == SRSF_MODE_PAR_EVEN)
    begin
      bad_parity = ^s.shift;
    end
    else if (mode == SRSF_MODE_PAR_ODD)
    begin
      bad_parity = ~^s.shift;
    end
    events = 3'h0;

    // receive frame timing, sampled in the middle of each bit
    next_s.bit_cyc = (s.bit_cyc == 8'h00) ? BIT_LAST : s.bit_cyc - 8'h01;
    case (s.rx_st)
      SRSF_RX_WAIT:
      begin
        next_s.bit_cyc = BIT_HALF;
        if (!s.rxd_sync)
        begin
          next_s.rx_st = SRSF_RX_START;
          next_s.idle = 1'b0;
        end
      end
      SRSF_RX_START:
      begin
        if (s.bit_cyc == 8'h00)
        begin
          next_s.bit_num = 4'h0;
          // a glitch shorter than half a bit is not a start bit
          next_s.rx_st = s.rxd_sync ? SRSF_RX_WAIT : SRSF_RX_DATA;
        end
      end
      SRSF_RX_DATA:
      begin
        if (s.bit_cyc == 8'h00)
        begin
          next_s.shift = {s.rxd_sync, s.shift[8:1]};
          next_s.bit_num = s.bit_num + 4'h1;
          if (s.bit_num == frame_bits - 4'h1)
          begin
            next_s.rx_st = is_async ? SRSF_RX_STOP : SRSF_RX_WAIT;
          end
        end
      end
      SRSF_RX_STOP:
      begin
        if (s.bit_cyc == 8'h00)
        begin
          next_s.rx_st = SRSF_RX_WAIT;
        end
      end
      default:
      begin
        next_s.rx_st = SRSF_RX_WAIT;
      end
    endcase
    // synchronous words have no stop bit, so they end on their last data bit
    if (!is_async && s.rx_st == SRSF_RX_DATA && s.bit_cyc == 8'h00
        && s.bit_num == frame_bits - 4'h1)
    begin
      frame_done = 1'b1;
    end
    if (s.rx_st == SRSF_RX_STOP && s.bit_cyc == 8'h00)
    begin
      frame_done = 1'b1;
      frame_fe = !s.rxd_sync;
    end
    if (!is_async)
    begin
      frame_fe = 1'b0;
    end

    // idle line: ones counted only while no frame is in progress
    if (s.rx_st != SRSF_RX_WAIT || !s.rxd_sync)
    begin
      next_s.idle_cyc = 8'h00;
      next_s.idle_ones = 4'h0;
    end
    else if (s.idle_ones != idle_target)
    begin
      next_s.idle_cyc = (s.idle_cyc == BIT_LAST) ? 8'h00 : s.idle_cyc + 8'h01;
      if (s.idle_cyc == BIT_LAST)
      begin
        next_s.idle_ones = s.idle_ones + 4'h1;
      end
    end
    if (s.rx_st == SRSF_RX_WAIT && s.rxd_sync && s.idle_ones == idle_target)
    begin
      next_s.idle = 1'b1;
    end

    // software side of the flags; hardware sets below win over these clears
    if (rd_status)
    begin
      next_s.clr_armed = 1'b1;
    end
    if (rd_rxdata)
    begin
      next_s.full = 1'b0;
      next_s.clr_armed = 1'b0;
      if (s.clr_armed)
      begin
        next_s.framing = 1'b0;
        next_s.parity = 1'b0;
        next_s.overrun = 1'b0;
      end
    end

    if (frame_done)
    begin
      if (s.full)
      begin
        next_s.overrun = 1'b1;
        next_s.framing = 1'b0;
        next_s.parity = 1'b0;
        events[SRSF_INT_ERROR] = 1'b1;
      end
      else if (!s.framing)
      begin
        word_moved = 1'b1;
        next_s.rx_data = word;
        next_s.full = 1'b1;
        next_s.framing = frame_fe;
        next_s.parity = next_s.parity || (is_parity && bad_parity);
        if (mode == SRSF_MODE_MULTIDROP)
        begin
          next_s.ninth = s.shift[8];
        end
        events[SRSF_INT_RX_FULL] = 1'b1;
        events[SRSF_INT_ERROR] = frame_fe || (is_parity && bad_parity);
      end
    end
    events[SRSF_INT_IDLE] = next_s.idle && !s.idle && s.ctrl[SRSF_CTRL_IDLE_IE];

    // any of the three reset sources drops the receiver and its flags
    if (flag_clear)
    begin
      next_s.ninth = 1'b0;
      next_s.framing = 1'b0;
      next_s.parity = 1'b0;
      next_s.overrun = 1'b0;
      next_s.full = 1'b0;
      next_s.idle = 1'b0;
      next_s.clr_armed = 1'b0;
      next_s.rx_st = SRSF_RX_WAIT;
      next_s.idle_ones = 4'h0;
      next_s.idle_cyc = 8'h00;
      events = 3'h0;
    end

    // register writes
    w1c = 3'h0;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        SRSF_OFF_CTRL:
        begin
          next_s.ctrl = {1'b0, bus_req.wdata[3:0]};
        end
        SRSF_OFF_INT_STAT:
        begin
          w1c = bus_req.wdata[2:0];
        end
        SRSF_OFF_INT_MASK:
        begin
          next_s.int_mask = bus_req.wdata[2:0];
        end
        default:
        begin
          w1c = 3'h0;
        end
      endcase
    end
    // an event in the cycle of its clear stays set
    next_s.int_stat = (s.int_stat & ~w1c) | events;

    // register reads, answered in the following cycle
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        SRSF_OFF_STATUS:
        begin
          next_s.rd_data = {16'h0000, s.ninth, s.framing, s.parity, s.overrun,
            s.idle, s.full, 2'h0};
        end
        SRSF_OFF_RXDATA:
        begin
          next_s.rd_data = {16'h0000, s.rx_data};
        end
        SRSF_OFF_CTRL:
        begin
          next_s.rd_data = {19'h00000, s.ctrl};
        end
        SRSF_OFF_INT_STAT:
        begin
          next_s.rd_data = {21'h000000, s.int_stat};
        end
        SRSF_OFF_INT_MASK:
        begin
          next_s.rd_data = {21'h000000, s.int_mask};
        end
        default:
        begin
          next_s.rd_data = 24'h000000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.rxd_meta <= 1'b1;
      s.rxd_sync <= 1'b1;
      s.rx_st <= SRSF_RX_WAIT;
      s.ctrl <= SRSF_CTRL_RESET;
      s.int_stat <= SRSF_INT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_status |=> (rd_data[23:8] == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits not zero");

  property p_ninth_kept_on_read;
    @(posedge sys_clk) disable iff (!rst_b)
    (bus_req.rd && !frame_done && !flag_clear) |=> $stable(s.ninth);
  endproperty
  a_ninth_kept_on_read: assert property (p_ninth_kept_on_read)
    else $error("ninth bit changed by a read");

  property p_reset_clears;
    @(posedge sys_clk) disable iff (!rst_b)
    (sw_reset || stop_req) |=> !(s.ninth || s.framing || s.parity || s.overrun);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("flags survived reset or stop");

  property p_framing_blocks;
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_done && s.framing && !s.full) |=> $stable(s.rx_data) && !s.full;
  endproperty
  a_framing_blocks: assert property (p_framing_blocks)
    else $error("word entered data register past framing error");

  property p_sync_no_framing;
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_done && mode == SRSF_MODE_SYNC8 && !s.framing) |=> !s.framing;
  endproperty
  a_sync_no_framing: assert property (p_sync_no_framing)
    else $error("framing error in synchronous mode");

  property p_overrun_keeps_data;
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_done && s.full && !flag_clear) |=> s.overrun && $stable(s.rx_data);
  endproperty
  a_overrun_keeps_data: assert property (p_overrun_keeps_data)
    else $error("overrun not flagged or data overwritten");

  property p_overrun_priority;
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_done && s.full) |=> !s.framing && !s.parity;
  endproperty
  a_overrun_priority: assert property (p_overrun_priority)
    else $error("framing or parity beside overrun");

  property p_clear_sequence;
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_status && !frame_done) ##1 (!bus_req.rd && !frame_done) ##1 (rd_rxdata && !frame_done) |=>
      !s.framing && !s.parity && !s.overrun && !s.clr_armed;
  endproperty
  a_clear_sequence: assert property (p_clear_sequence)
    else $error("error flags not cleared by read sequence");

  property p_full_on_move;
    @(posedge sys_clk) disable iff (!rst_b)
    (word_moved && !flag_clear) |=> s.full && (s.rx_data == $past(word));
  endproperty
  a_full_on_move: assert property (p_full_on_move)
    else $error("data full not set on transfer");
endmodule

// ==== design/srsf_pkg.sv ====
// constants, bus carrier and state types for the receive status flag block
package srsf_pkg;
  localparam int SRSF_AW = 5;
  localparam int SRSF_DW = 24;
  // register byte offsets
  localparam logic [4:0] SRSF_OFF_STATUS = 5'h00;
  localparam logic [4:0] SRSF_OFF_RXDATA = 5'h04;
  localparam logic [4:0] SRSF_OFF_CTRL = 5'h08;
  localparam logic [4:0] SRSF_OFF_INT_STAT = 5'h0c;
  localparam logic [4:0] SRSF_OFF_INT_MASK = 5'h10;
  // serial_status bit positions
  localparam int SRSF_BIT_NINTH = 7;
  localparam int SRSF_BIT_FRAMING = 6;
  localparam int SRSF_BIT_PARITY = 5;
  localparam int SRSF_BIT_OVERRUN = 4;
  localparam int SRSF_BIT_IDLE = 3;
  localparam int SRSF_BIT_FULL = 2;
  // control register fields
  localparam int SRSF_CTRL_MODE_LSB = 0;
  localparam int SRSF_CTRL_IDLE_IE = 3;
  localparam int SRSF_CTRL_INDIV_RST = 4;
  localparam logic [4:0] SRSF_CTRL_RESET = 5'h02;
  // interrupt status bit positions
  localparam int SRSF_INT_RX_FULL = 0;
  localparam int SRSF_INT_ERROR = 1;
  localparam int SRSF_INT_IDLE = 2;
  localparam logic [2:0] SRSF_INT_RESET = 3'h0;
  // word format codes
  localparam logic [2:0] SRSF_MODE_SYNC8 = 3'h0;
  localparam logic [2:0] SRSF_MODE_ASYNC10 = 3'h2;
  localparam logic [2:0] SRSF_MODE_PAR_EVEN = 3'h4;
  localparam logic [2:0] SRSF_MODE_PAR_ODD = 3'h5;
  localparam logic [2:0] SRSF_MODE_MULTIDROP = 3'h6;
  // idle line: ones counted in bit times
  localparam logic [3:0] SRSF_IDLE_ONES_10 = 4'ha;
  localparam logic [3:0] SRSF_IDLE_ONES_11 = 4'hb;
  localparam logic [3:0] SRSF_DATA_BITS = 4'h8;
  // clock cycles per serial bit time
  localparam int SRSF_BIT_CYCLES = 16;

  typedef struct packed {
    logic [4:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } srsf_bus_req_t;

  typedef enum logic [1:0] {SRSF_RX_WAIT, SRSF_RX_START, SRSF_RX_DATA, SRSF_RX_STOP} srsf_rx_st_t;

  typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    srsf_rx_st_t rx_st;
    logic [7:0] bit_cyc;
    logic [3:0] bit_num;
    logic [8:0] shift;
    logic [3:0] idle_ones;
    logic [7:0] idle_cyc;
    logic [7:0] rx_data;
    logic ninth;
    logic framing;
    logic parity;
    logic overrun;
    logic idle;
    logic full;
    logic clr_armed;
    logic [4:0] ctrl;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [23:0] rd_data;
  } srsf_state_t;
endpackage

// ==== testbench/srsf_tx_partner.sv ====
// behavioural remote transmitter driving the serial receive line
`timescale 1ns/10ps
module srsf_tx_partner
#(
  parameter int BIT_CYCLES = 16
)
(
  input wire logic sys_clk,
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (BIT_CYCLES) @(posedge sys_clk);
  endtask
  // start, eight data lsb first, optional type or parity bit, stop level as asked
  task automatic send(input logic [7:0] d, input logic n9, input logic b9, input logic stp);
    @(posedge sys_clk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      bit_out(d[i]);
    end
    if (n9)
    begin
      bit_out(b9);
    end
    bit_out(stp);
    // a low stop is only one bit long: the line goes back to its idle high level
    rxd <= 1'b1;
  endtask
endmodule

// ==== testbench/test_serial_receive_status_flags.sv ====
// self-checking bench for the receive status flag block
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module test_serial_receive_status_flags;
  import srsf_pkg::*;
  localparam int BC = 8;
  localparam logic [23:0] F_N = 24'h1 << SRSF_BIT_NINTH;
  localparam logic [23:0] F_F = 24'h1 << SRSF_BIT_FRAMING;
  localparam logic [23:0] F_P = 24'h1 << SRSF_BIT_PARITY;
  localparam logic [23:0] F_O = 24'h1 << SRSF_BIT_OVERRUN;
  localparam logic [23:0] F_I = 24'h1 << SRSF_BIT_IDLE;
  localparam logic [23:0] F_D = 24'h1 << SRSF_BIT_FULL;
  // idle is left out of the flag mask: it moves on its own with line time
  localparam logic [23:0] MF = F_N | F_F | F_P | F_O | F_D;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  srsf_bus_req_t bus_req = '0;
  logic sw_reset = 1'b0;
  logic stop_req = 1'b0;
  logic [23:0] rd_data;
  logic rxd;
  logic irq;
  logic [23:0] v;
  logic pb;
  int errors = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  srsf_rx_status #(.BIT_CYCLES(BC)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .rxd(rxd), .sw_reset(sw_reset), .stop_req(stop_req), .irq(irq));
  srsf_tx_partner #(.BIT_CYCLES(BC)) far (.sys_clk(sys_clk), .rxd(rxd));
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic frame(input logic [7:0] d, input logic n9, input logic b9, input logic stp);
    far.send(d, n9, b9, stp);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(SRSF_OFF_STATUS, v);
    `CHK(v, 24'h0)
    rd(SRSF_OFF_CTRL, v);
    `CHK(v, {19'h0, SRSF_CTRL_RESET})
    wr(SRSF_OFF_STATUS, 24'hffffff);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v, 24'h0)
    rd(5'h14, v);
    `CHK(v, 24'h0)
    wr(SRSF_OFF_INT_MASK, 24'h3);
    frame(8'ha5, 1'b0, 1'b0, 1'b1);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & ~(MF | F_I), 24'h0)
    `CHK(v & MF, F_D)
    `CHK(irq, 1'b1)
    rd(SRSF_OFF_RXDATA, v);
    `CHK(v, 24'ha5)
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, 24'h0)
    wr(SRSF_OFF_INT_STAT, 24'h7);
    settle();
    `CHK(irq, 1'b0)
    // a data read first drops the latch left armed by the status read above
    rd(SRSF_OFF_RXDATA, v);
    frame(8'h3c, 1'b0, 1'b0, 1'b0);
    rd(SRSF_OFF_RXDATA, v);
    `CHK(v, 24'h3c)
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, F_F)
    frame(8'h11, 1'b0, 1'b0, 1'b1);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, F_F)
    rd(SRSF_OFF_INT_STAT, v);
    `CHK(v & 24'h2, 24'h2)
    rd(SRSF_OFF_RXDATA, v);
    `CHK(v, 24'h3c)
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, 24'h0)
    wr(SRSF_OFF_INT_STAT, 24'h7);
    for (int m = 4; m <= 5; m++)
    begin
      wr(SRSF_OFF_CTRL, 24'(m));
      pb = (m == 5);
      rd(SRSF_OFF_RXDATA, v);
      frame(8'h5a, 1'b1, ^8'h5a ^ pb, 1'b1);
      frame(8'h77, 1'b1, ~^8'h77 ^ pb, 1'b1);
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, F_O | F_D)
      rd(SRSF_OFF_RXDATA, v);
      `CHK(v, 24'h5a)
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, 24'h0)
      rd(SRSF_OFF_RXDATA, v);
      frame(8'h77, 1'b1, ~^8'h77 ^ pb, 1'b1);
      rd(SRSF_OFF_RXDATA, v);
      frame(8'h42, 1'b1, ^8'h42 ^ pb, 1'b1);
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, F_P | F_D)
      rd(SRSF_OFF_RXDATA, v);
      `CHK(v, 24'h42)
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, 24'h0)
    end
    wr(SRSF_OFF_CTRL, {21'h0, SRSF_MODE_MULTIDROP});
    rd(SRSF_OFF_RXDATA, v);
    frame(8'h81, 1'b1, 1'b1, 1'b1);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, F_N | F_D)
    rd(SRSF_OFF_RXDATA, v);
    `CHK(v, 24'h81)
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, F_N)
    frame(8'h82, 1'b1, 1'b0, 1'b1);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & MF, F_D)
    for (int k = 0; k < 3; k++)
    begin
      wr(SRSF_OFF_CTRL, {21'h0, SRSF_MODE_MULTIDROP});
      rd(SRSF_OFF_RXDATA, v);
      frame(8'h99, 1'b1, 1'b1, 1'b0);
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, F_N | F_F | F_D)
      if (k == 2)
      begin
        wr(SRSF_OFF_CTRL, 24'h16);
      end
      else
      begin
        @(posedge sys_clk);
        sw_reset <= (k == 0);
        stop_req <= (k == 1);
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        stop_req <= 1'b0;
      end
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & MF, 24'h0)
    end
    // sync mode ignores the stop slot; the low level there starts a second word
    wr(SRSF_OFF_CTRL, {21'h0, SRSF_MODE_SYNC8});
    frame(8'h0f, 1'b0, 1'b0, 1'b0);
    repeat (12 * BC) @(posedge sys_clk);
    rd(SRSF_OFF_STATUS, v);
    `CHK(v & F_F, 24'h0)
    wr(SRSF_OFF_CTRL, 24'h12);
    wr(SRSF_OFF_INT_STAT, 24'h7);
    wr(SRSF_OFF_INT_MASK, 24'h4);
    wr(SRSF_OFF_CTRL, 24'h0a);
    for (int j = 0; j < 2; j++)
    begin
      frame(8'h55, 1'b0, 1'b0, 1'b1);
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & F_I, 24'h0)
      `CHK(irq, 1'b0)
      repeat (12 * BC) @(posedge sys_clk);
      rd(SRSF_OFF_STATUS, v);
      `CHK(v & F_I, F_I)
      `CHK(irq, 1'b1)
      rd(SRSF_OFF_RXDATA, v);
      if (j == 0)
      begin
        wr(SRSF_OFF_INT_STAT, 24'h4);
      end
      else
      begin
        wr(SRSF_OFF_INT_MASK, 24'h0);
      end
      settle();
      `CHK(irq, 1'b0)
    end
    rd(SRSF_OFF_INT_STAT, v);
    `CHK(v & 24'h4, 24'h4)
    report_and_stop();
  end
endmodule
